// *** rtl/imsu_core.sv ***
// ============================================================
// exception unit: pending exceptions, masking, state save/update
// assumes one core clock, sources synchronous, pipeline accepts
// a pending interrupt with pipeAccept and supplies curPc
//
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "imsu_regs.svh"
module imsu_core
    import imsu_pkg::*;
(
    // clock, reset, enable
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic        ce,
    // register port
    input  wire imsu_bus_t   bus,
    output logic      [31:0] busRdata,
    // exception sources
    input  wire imsu_src_t   src,
    input  wire logic        dataFault,
    input  wire logic [0:31] faultAddr,
    // pipeline side
    input  wire logic        pipeAccept,
    input  wire logic [0:31] curPc,
    input  wire logic        retCrit,
    input  wire logic        retNoncrit,
    output logic             irqPending,
    output imsu_take_t       take,
    output logic      [0:31] machineState
);
    // ============================================================
    // registers
    logic [0:31] saveStateNoncrit;
    logic [0:31] saveStateCrit;
    logic [0:31] savePcNoncrit;
    logic [0:31] savePcCrit;
    logic [0:31] vectorBase;
    logic [0:31] excSyndrome;
    logic [0:31] dataFaultAddr;
    logic [0:31] timerStatus;
    logic [0:31] dbgStatus;
    logic        wdogReq;
    logic        dbgLive;

    logic [`IMSU_NSRC-1:0] req;
    logic [`IMSU_NSRC-1:0] grant;
    logic                  anyReq;
    logic [2:0]            causeIdx;
    imsu_cause_t           cause;
    logic                  takeNow;
    logic                  critTake;
    logic [0:31]           keepMask;
    logic [0:31]           wd;
    logic [31:0]           next_rdata;

    // ============================================================
    // decode
    assign wd = bus.wdata;
    function automatic logic hit(input logic [7:0] off);
        hit = ce && bus.wr && (bus.addr == off);
    endfunction

    // ============================================================
    // request vector, index 0 has highest priority
    always_comb begin
        req[0] = src.busErr && machineState[`IMSU_MS_ME];
        req[1] = src.critIn && machineState[`IMSU_MS_CE];
        req[2] = wdogReq && machineState[`IMSU_MS_CE];
        req[3] = machineState[`IMSU_MS_DE]
                 && (dbgStatus[`IMSU_DS_IDE] || dbgLive);
        req[4] = src.extIn && machineState[`IMSU_MS_EE];
        // flag-driven, so clearing the flag withdraws it
        req[5] = timerStatus[`IMSU_TS_FIT]
                 && machineState[`IMSU_MS_EE];
        req[6] = timerStatus[`IMSU_TS_PIT]
                 && machineState[`IMSU_MS_EE];
    end

    // one winner; losers keep their status and wait
    imsu_prio #(
        .N (`IMSU_NSRC)
    ) u_prio (
        .req   (req),
        .grant (grant),
        .any   (anyReq),
        .idx   (causeIdx)
    );

    assign cause      = imsu_cause_t'(causeIdx);
    assign irqPending = anyReq;
    assign takeNow    = anyReq && pipeAccept;
    assign critTake   = (cause == CAUSE_MCHK) || (cause == CAUSE_CRIT)
                        || (cause == CAUSE_WDOG) || (cause == CAUSE_DBG);

    // enables that survive entry, per cause
    always_comb begin
        if (cause == CAUSE_MCHK) begin
            keepMask = `IMSU_KEEP_MCHK;
        end else if (critTake) begin
            keepMask = `IMSU_KEEP_CRIT;
        end else begin
            keepMask = `IMSU_KEEP_NONCRIT;
        end
    end

    // ============================================================
    // machine_state: entry beats return, return beats software
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            machineState <= `IMSU_MS_RESET;
        end else if (ce) begin
            if (takeNow) begin
                // clears all but 14,19,22 (noncritical), all but 19 (critical), all bits (machine check)
                machineState <= machineState & keepMask;
            end else if (retCrit) begin
                machineState <= saveStateCrit;
            end else if (retNoncrit) begin
                machineState <= saveStateNoncrit;
            end else if (hit(`IMSU_OFF_MS)) begin
                machineState <= wd;
            end
        end
    end

    // ============================================================
    // save/restore registers
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            saveStateNoncrit <= `IMSU_REG_RESET;
            saveStateCrit    <= `IMSU_REG_RESET;
            savePcNoncrit    <= `IMSU_REG_RESET;
            savePcCrit       <= `IMSU_REG_RESET;
        end else if (ce) begin
            if (takeNow && critTake) begin
                saveStateCrit <= machineState;
                savePcCrit    <= {curPc[0:29], 2'h0};
            end else begin
                if (hit(`IMSU_OFF_SST_CR)) saveStateCrit <= wd;
                if (hit(`IMSU_OFF_SPC_CR)) savePcCrit <= {wd[0:29], 2'h0};
            end
            if (takeNow && !critTake) begin
                saveStateNoncrit <= machineState;
                savePcNoncrit    <= {curPc[0:29], 2'h0};
            end else begin
                if (hit(`IMSU_OFF_SST_NC)) saveStateNoncrit <= wd;
                if (hit(`IMSU_OFF_SPC_NC)) begin
                    savePcNoncrit <= {wd[0:29], 2'h0};
                end
            end
        end
    end

    // ============================================================
    // vector base, syndrome and data fault address
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            vectorBase    <= `IMSU_REG_RESET;
            excSyndrome   <= `IMSU_REG_RESET;
            dataFaultAddr <= `IMSU_REG_RESET;
        end else if (ce) begin
            if (hit(`IMSU_OFF_VBASE)) vectorBase <= wd;
            if (hit(`IMSU_OFF_SYND)) begin
                excSyndrome <= wd;
            end
            // recorded on every bus error, held until software rewrites it
            if (src.busErr) excSyndrome[`IMSU_SY_MCI] <= 1'b1;
            if (dataFault) begin
                dataFaultAddr <= faultAddr;
            end else if (hit(`IMSU_OFF_DFA)) begin
                dataFaultAddr <= wd;
            end
        end
    end

    // ============================================================
    // timer status, write one to clear; a same-cycle event wins
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            timerStatus <= `IMSU_REG_RESET;
        end else if (ce) begin
            if (hit(`IMSU_OFF_TSTAT)) begin
                timerStatus <= timerStatus & ~wd;
            end
            if (src.pitTimeout) timerStatus[`IMSU_TS_PIT] <= 1'b1;
            if (src.fitTimeout) timerStatus[`IMSU_TS_FIT] <= 1'b1;
            if (src.wdogTimeout) begin
                timerStatus[`IMSU_TS_WDOG] <= 1'b1;
            end
        end
    end

    // watchdog fires only on a time-out that finds the flag clear
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            wdogReq <= 1'b0;
        end else if (ce) begin
            if (src.wdogTimeout && !timerStatus[`IMSU_TS_WDOG]) begin
                wdogReq <= 1'b1;
            end else if (!timerStatus[`IMSU_TS_WDOG]
                         || (takeNow && cause == CAUSE_WDOG)) begin
                wdogReq <= 1'b0;
            end
        end
    end

    // ============================================================
    // debug status, write one to clear; event bits always recorded
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            dbgStatus <= `IMSU_REG_RESET;
        end else if (ce) begin
            if (hit(`IMSU_OFF_DSTAT)) begin
                dbgStatus <= dbgStatus & ~wd;
            end
            if (src.dbgEvent) begin
                dbgStatus[`IMSU_DS_EV_LO:`IMSU_DS_EV_HI] <=
                    dbgStatus[`IMSU_DS_EV_LO:`IMSU_DS_EV_HI]
                    | src.dbgWhich;
                if (!machineState[`IMSU_MS_DE]) begin
                    dbgStatus[`IMSU_DS_IDE] <= 1'b1;
                end
            end
        end
    end

    // an unmasked debug event is held until taken, not dropped
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            dbgLive <= 1'b0;
        end else if (ce) begin
            if (src.dbgEvent && machineState[`IMSU_MS_DE]) begin
                dbgLive <= 1'b1;
            end else if (takeNow && cause == CAUSE_DBG) begin
                dbgLive <= 1'b0;
            end
        end
    end

    // ============================================================
    // take result towards the pipeline
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            take <= '0;
        end else if (ce) begin
            take.valid  <= takeNow;
            take.cause  <= cause;
            // offset is (cause+1) pages of 256 bytes
            take.vector <= {vectorBase[0:15], 5'h00,
                            causeIdx + 3'h1, 8'h00};
        end
    end

    // ============================================================
    // read data, one cycle after the strobe; unmapped reads zero
    always_comb begin
        case (bus.addr)
            `IMSU_OFF_MS:     next_rdata = machineState;
            `IMSU_OFF_SPC_NC: next_rdata = savePcNoncrit;
            `IMSU_OFF_SST_NC: next_rdata = saveStateNoncrit;
            `IMSU_OFF_SPC_CR: next_rdata = savePcCrit;
            `IMSU_OFF_SST_CR: next_rdata = saveStateCrit;
            `IMSU_OFF_VBASE:  next_rdata = vectorBase;
            `IMSU_OFF_SYND:   next_rdata = excSyndrome;
            `IMSU_OFF_DFA:    next_rdata = dataFaultAddr;
            `IMSU_OFF_TSTAT:  next_rdata = timerStatus;
            `IMSU_OFF_DSTAT:  next_rdata = dbgStatus;
            default:          next_rdata = 32'h00000000;
        endcase
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            busRdata <= 32'h00000000;
        end else if (ce) begin
            busRdata <= bus.rd ? next_rdata : 32'h00000000;
        end
    end

    // ============================================================
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    sequence s_taking(imsu_cause_t c);
        ce && takeNow && cause == c;
    endsequence

    sequence s_entry;
        ce && takeNow;
    endsequence

    chk_ext_gated: assert property (
        s_taking(CAUSE_EXT) |-> machineState[`IMSU_MS_EE] && src.extIn)
        else $error("external taken while masked");

    chk_crit_gated: assert property (
        s_taking(CAUSE_CRIT) |-> machineState[`IMSU_MS_CE] && src.critIn)
        else $error("critical input taken while masked");

    chk_pit_pending: assert property (
        ce && src.pitTimeout |=> timerStatus[`IMSU_TS_PIT])
        else $error("interval flag not set");

    chk_wdog_once: assert property (
        ce && timerStatus[`IMSU_TS_WDOG] && !wdogReq |=> !wdogReq)
        else $error("watchdog re-armed while flag set");

    chk_mchk_live: assert property (
        s_taking(CAUSE_MCHK) |-> src.busErr)
        else $error("machine check without bus error");

    chk_state_saved: assert property (
        s_entry ##0 critTake |=> saveStateCrit == $past(machineState))
        else $error("critical state not saved");

    chk_entry_clear: assert property (
        s_entry |=> (machineState & ~`IMSU_KEEP_NONCRIT) == 32'h00000000
                    && !machineState[`IMSU_MS_EE])
        else $error("state bits survived entry");

    chk_pc_aligned: assert property (
        savePcCrit[30:31] == 2'h0 && savePcNoncrit[30:31] == 2'h0)
        else $error("saved address not word aligned");

    chk_vector_form: assert property (
        s_entry |=> take.valid && take.vector[0:15] == $past(vectorBase[0:15]))
        else $error("handler address prefix wrong");

    chk_dbg_masked: assert property (
        ce && src.dbgEvent && !machineState[`IMSU_MS_DE]
        |=> dbgStatus[`IMSU_DS_IDE])
        else $error("imprecise debug flag not set");

    chk_one_grant: assert property (
        $onehot0(grant) && (anyReq == (grant != '0)))
        else $error("more than one cause granted");
endmodule

// *** rtl/imsu_regs.svh ***
// ============================================================
// register offsets, field positions, reset values and masks
// assumes bit 0 is the most significant bit of every register
`ifndef IMSU_REGS_SVH
`define IMSU_REGS_SVH

// ============================================================
// register offsets on the plain register port
`define IMSU_OFF_MS       8'h00
`define IMSU_OFF_SPC_NC   8'h04
`define IMSU_OFF_SST_NC   8'h08
`define IMSU_OFF_SPC_CR   8'h0C
`define IMSU_OFF_SST_CR   8'h10
`define IMSU_OFF_VBASE    8'h14
`define IMSU_OFF_SYND     8'h18
`define IMSU_OFF_DFA      8'h1C
`define IMSU_OFF_TSTAT    8'h20
`define IMSU_OFF_DSTAT    8'h24

// ============================================================
// machine_state fields, numbered from the most significant bit
`define IMSU_MS_WE        13
`define IMSU_MS_CE        14
`define IMSU_MS_EE        16
`define IMSU_MS_PR        17
`define IMSU_MS_ME        19
`define IMSU_MS_DWE       21
`define IMSU_MS_DE        22
`define IMSU_MS_IR        26
`define IMSU_MS_DR        27
`define IMSU_MS_RESET     32'h00000000
// bits kept on entry: noncritical keeps 14,19,22; critical keeps 19
`define IMSU_KEEP_NONCRIT 32'h00021200
`define IMSU_KEEP_CRIT    32'h00001000
`define IMSU_KEEP_MCHK    32'h00000000

// ============================================================
// status fields and reset values
`define IMSU_TS_WDOG      1
`define IMSU_TS_PIT       4
`define IMSU_TS_FIT       5
`define IMSU_DS_IDE       0
`define IMSU_DS_EV_LO     1
`define IMSU_DS_EV_HI     5
`define IMSU_SY_MCI       0
`define IMSU_REG_RESET    32'h00000000
`define IMSU_NSRC         7

`endif

// *** rtl/imsu_pkg.sv ***
// ============================================================
// types shared by the exception unit files
// assumes imsu_regs.svh supplies the numeric constants
package imsu_pkg;
    // interrupt causes, listed from highest to lowest priority
    typedef enum logic [2:0] {
        CAUSE_MCHK, CAUSE_CRIT, CAUSE_WDOG, CAUSE_DBG,
        CAUSE_EXT, CAUSE_FIT, CAUSE_PIT
    } imsu_cause_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } imsu_bus_t;

    typedef struct packed {
        logic       critIn;
        logic       extIn;
        logic       pitTimeout;
        logic       fitTimeout;
        logic       wdogTimeout;
        logic       dbgEvent;
        logic [4:0] dbgWhich;
        logic       busErr;
    } imsu_src_t;

    typedef struct packed {
        logic        valid;
        imsu_cause_t cause;
        logic [0:31] vector;
    } imsu_take_t;
endpackage

// *** rtl/imsu_prio.sv ***
// ============================================================
// fixed priority picker, request 0 wins
// assumes requests are combinational levels of one clock domain
`timescale 1ns/1ps
module imsu_prio #(
    parameter int N = 7
) (
    // requests and grant
    input  wire logic [N-1:0]         req,
    output logic      [N-1:0]         grant,
    output logic                      any,
    output logic      [$clog2(N)-1:0] idx
);
    logic [N-1:0] lower;

    // lower[i] is set when any higher-priority request is present
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_pick
            if (i == 0) begin : g_first
                assign lower[i] = 1'b0;
            end else begin : g_rest
                assign lower[i] = lower[i-1] | req[i-1];
            end
            assign grant[i] = req[i] & ~lower[i];
        end
    endgenerate

    assign any = |req;

    // encode the single granted line
    always_comb begin
        idx = '0;
        for (int k = N - 1; k >= 0; k--) begin
            if (grant[k]) begin
                idx = k[$clog2(N)-1:0];
            end
        end
    end
endmodule

// *** sim/imsu_pipe_model.sv ***
// ============================================================
// pipeline stand-in: offers interrupt slots and return addresses
// assumes the bench drives stall just after a rising clock edge
`timescale 1ns/1ps
module imsu_pipe_model (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        resetn,
    // bench control
    input  wire logic        stall,
    // pipeline side of the exception unit
    output logic             pipeAccept,
    output logic      [0:31] curPc,
    output logic      [0:31] lastPc
);
    // ========================================================
    // acceptance trails stall by a cycle, as a real pipe drains
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pipeAccept <= 1'b0;
        end else begin
            pipeAccept <= !stall;
        end
    end

    // ========================================================
    // address walks every cycle; low bits set so alignment shows
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            curPc  <= 32'h00001003;
            lastPc <= 32'h00000000;
        end else begin
            curPc  <= curPc + 32'h00000004;
            lastPc <= curPc; // address the unit saw at this edge
        end
    end
endmodule

// *** sim/interrupt_mask_and_state_update_tb.sv ***
// ============================================================
// self-checking bench for the exception unit
// assumes imsu_core and the pipeline stand-in imsu_pipe_model
`timescale 1ns/1ps
`include "imsu_regs.svh"
module interrupt_mask_and_state_update_tb
    import imsu_pkg::*;
;
    // ========================================================
    // machine_state masks and watchdog flag in bus bit order, vector base
    localparam logic [31:0] ALL = 32'hFFFFFFFF;
    localparam logic [31:0] CEN = 32'h00020000;
    localparam logic [31:0] EEN = 32'h00008000;
    localparam logic [31:0] MEN = 32'h00001000;
    localparam logic [31:0] DEN = 32'h00000200;
    localparam logic [31:0] VB  = 32'hABCD1234;
    localparam logic [31:0] WDF = 32'h40000000;
    // source pulse patterns: pit, fit, watchdog, debug with events
    localparam logic [11:0] P_PIT = 12'h200;
    localparam logic [11:0] P_FIT = 12'h100;
    localparam logic [11:0] P_WD  = 12'h080;
    localparam logic [11:0] P_DBG = 12'h06A;

    logic        core_clk;
    logic        resetn;
    logic        ce;
    logic        dataFault;
    logic        retCrit;
    logic        retNoncrit;
    logic        stall;
    logic        pipeAccept;
    logic        irqPending;
    logic [0:31] faultAddr;
    logic [0:31] curPc;
    logic [0:31] lastPc;
    logic [0:31] machineState;
    logic [31:0] busRdata;
    logic [31:0] savedPc;
    logic [31:0] tmrFlag;
    imsu_bus_t   bus;
    imsu_src_t   src;
    imsu_take_t  take;
    int          badCount;
    int          checks;

    // ========================================================
    // unit under test and pipeline stand-in
    imsu_core u_imsu_core (
        .core_clk     (core_clk),
        .resetn       (resetn),
        .ce           (ce),
        .bus          (bus),
        .busRdata     (busRdata),
        .src          (src),
        .dataFault    (dataFault),
        .faultAddr    (faultAddr),
        .pipeAccept   (pipeAccept),
        .curPc        (curPc),
        .retCrit      (retCrit),
        .retNoncrit   (retNoncrit),
        .irqPending   (irqPending),
        .take         (take),
        .machineState (machineState)
    );
    imsu_pipe_model u_imsu_pipe_model (
        .core_clk   (core_clk),
        .resetn     (resetn),
        .stall      (stall),
        .pipeAccept (pipeAccept),
        .curPc      (curPc),
        .lastPc     (lastPc)
    );

    // 20 MHz core clock
    always #25 core_clk = ~core_clk;

    // ========================================================
    // verdict, the single place the run ends
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, badCount);
        if (badCount == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            badCount++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic endTest(input string name);
        $display("test %s done", name);
    endtask

    // one-cycle write strobe; a gap cycle follows so strobes never merge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus <= '0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        bus <= '{addr: a, wdata: 32'h00000000, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus <= '0;
        #1;
        cmp(busRdata, exp);
    endtask

    // raise chosen pulse sources for one cycle, levels untouched
    task automatic pulse(input logic [11:0] p);
        @(posedge core_clk);
        src <= imsu_src_t'(src | p);
        @(posedge core_clk);
        src <= imsu_src_t'(src & ~p);
    endtask

    // bounded wait for an entry, then cause, vector and new state
    task automatic expTake(input imsu_cause_t c, input logic [31:0] ms);
        int i;
        i = 0;
        do begin
            @(posedge core_clk);
            #1;
            i++;
        end while (take.valid !== 1'b1 && i < 20);
        if (take.valid !== 1'b1) begin
            badCount++;
            wrap_up();
        end
        savedPc = {lastPc[0:29], 2'b00};
        cmp({29'h0, take.cause}, {29'h0, c});
        cmp(take.vector, {VB[31:16], 8'(c + 1), 8'h00});
        cmp(machineState, ms);
    endtask

    task automatic expNone(input int n);
        repeat (n) begin
            @(posedge core_clk);
            #1;
            cmp({31'h0, take.valid}, 32'h00000000);
        end
    endtask

    // ========================================================
    // main sequence
    initial begin
        core_clk = 1'b0;
        resetn = 1'b0;
        ce = 1'b1;
        bus = '0;
        src = '0;
        dataFault = 1'b0;
        faultAddr = '0;
        retCrit = 1'b0;
        retNoncrit = 1'b0;
        stall = 1'b0;
        badCount = 0;
        checks = 0;
        repeat (5) @(posedge core_clk);
        resetn <= 1'b1;
        rd(`IMSU_OFF_MS, 32'h00000000);
        wr(8'h40, ALL);
        rd(8'h40, 32'h00000000);
        wr(`IMSU_OFF_VBASE, VB);
        wr(`IMSU_OFF_SPC_NC, ALL);
        rd(`IMSU_OFF_SPC_NC, 32'hFFFFFFFC);
        endTest("reset_map");
        // critical entry from a fully set state, then critical return
        @(posedge core_clk);
        src.critIn <= 1'b1;
        wr(`IMSU_OFF_MS, ALL);
        expTake(CAUSE_CRIT, 32'h00001000);
        @(posedge core_clk);
        src.critIn <= 1'b0;
        rd(`IMSU_OFF_SST_CR, ALL);
        rd(`IMSU_OFF_SPC_CR, savedPc);
        @(posedge core_clk);
        retCrit <= 1'b1;
        @(posedge core_clk);
        retCrit <= 1'b0;
        #1;
        cmp(machineState, ALL);
        wr(`IMSU_OFF_MS, 32'h00000000);
        endTest("critical");
        // external masked first, then noncritical entry and return
        @(posedge core_clk);
        src.extIn <= 1'b1;
        expNone(4);
        wr(`IMSU_OFF_MS, ALL);
        expTake(CAUSE_EXT, 32'h00021200);
        @(posedge core_clk);
        src.extIn <= 1'b0;
        rd(`IMSU_OFF_SST_NC, ALL);
        rd(`IMSU_OFF_SPC_NC, savedPc);
        @(posedge core_clk);
        retNoncrit <= 1'b1;
        @(posedge core_clk);
        retNoncrit <= 1'b0;
        #1;
        cmp(machineState, ALL);
        wr(`IMSU_OFF_MS, 32'h00000000);
        endTest("external");
        // timers: flag held while masked, cleared flag stays quiet
        for (int i = 0; i < 2; i++) begin
            tmrFlag = (i == 0) ? 32'h08000000 : 32'h04000000;
            pulse((i == 0) ? P_PIT : P_FIT);
            rd(`IMSU_OFF_TSTAT, tmrFlag);
            expNone(3);
            wr(`IMSU_OFF_MS, EEN);
            expTake((i == 0) ? CAUSE_PIT : CAUSE_FIT, 0);
            wr(`IMSU_OFF_TSTAT, tmrFlag);
            wr(`IMSU_OFF_MS, EEN);
            expNone(4);
            wr(`IMSU_OFF_MS, 32'h00000000);
        end
        endTest("timers");
        // watchdog fires once per flag, re-armed by clearing it
        wr(`IMSU_OFF_MS, CEN);
        pulse(P_WD);
        expTake(CAUSE_WDOG, 32'h00000000);
        rd(`IMSU_OFF_TSTAT, WDF);
        wr(`IMSU_OFF_MS, CEN);
        pulse(P_WD);
        expNone(4);
        wr(`IMSU_OFF_TSTAT, WDF);
        pulse(P_WD);
        expTake(CAUSE_WDOG, 32'h00000000);
        wr(`IMSU_OFF_TSTAT, WDF);
        endTest("watchdog");
        // debug event while masked leaves imprecise flag and events
        pulse(P_DBG);
        rd(`IMSU_OFF_DSTAT, 32'hD4000000);
        wr(`IMSU_OFF_MS, DEN);
        expTake(CAUSE_DBG, 32'h00000000);
        wr(`IMSU_OFF_DSTAT, 32'hFC000000);
        endTest("debug");
        // machine check only with a live bus error
        wr(`IMSU_OFF_MS, MEN);
        @(posedge core_clk);
        src.busErr <= 1'b1;
        expTake(CAUSE_MCHK, 32'h00000000);
        @(posedge core_clk);
        src.busErr <= 1'b0;
        rd(`IMSU_OFF_SYND, 32'h80000000);
        wr(`IMSU_OFF_MS, MEN);
        expNone(5);
        endTest("machine_check");
        // two causes held back by a stalled pipe, taken one at a time
        @(posedge core_clk);
        stall <= 1'b1;
        src.critIn <= 1'b1;
        src.extIn <= 1'b1;
        wr(`IMSU_OFF_MS, CEN | EEN);
        expNone(3);
        cmp({31'h0, irqPending}, 32'h00000001);
        @(posedge core_clk);
        stall <= 1'b0;
        expTake(CAUSE_CRIT, 32'h00000000);
        @(posedge core_clk);
        src.critIn <= 1'b0;
        wr(`IMSU_OFF_MS, EEN);
        expTake(CAUSE_EXT, 32'h00000000);
        @(posedge core_clk);
        src.extIn <= 1'b0;
        endTest("priority");
        // faulting data address capture
        @(posedge core_clk);
        dataFault <= 1'b1;
        faultAddr <= 32'h0000BEE4;
        @(posedge core_clk);
        dataFault <= 1'b0;
        rd(`IMSU_OFF_DFA, 32'h0000BEE4);
        endTest("data_fault");
        // clock enable low: a write must not land anywhere
        @(posedge core_clk);
        ce <= 1'b0;
        wr(`IMSU_OFF_VBASE, ALL);
        ce <= 1'b1;
        rd(`IMSU_OFF_VBASE, VB);
        endTest("freeze");
        wrap_up();
    end
endmodule
